// ===== dsa_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants and types of the address/command block
package dsa_pkg;

   // ==========================================================
   // Clock and times (microseconds)
   localparam int unsigned CLK_MHZ           = 100;
   localparam int unsigned T_LISTEN_START_US = 1000;
   localparam int unsigned T_DISC_PER_US     = 250;
   localparam int unsigned T_RAMP_DLY_US     = 20;
   localparam int unsigned T_RAMP_US         = 128;
   localparam int unsigned T_HOLD_US         = 64;

   // Cycle counts derived from the times
   localparam int unsigned LISTEN_START_CYC = T_LISTEN_START_US * CLK_MHZ;
   localparam int unsigned DISC_PER_CYC     = T_DISC_PER_US * CLK_MHZ;
   localparam int unsigned RAMP_DLY_CYC     = T_RAMP_DLY_US * CLK_MHZ;
   localparam int unsigned RAMP_CYC         = T_RAMP_US * CLK_MHZ;
   localparam int unsigned HOLD_CYC         = T_HOLD_US * CLK_MHZ;

   // ==========================================================
   // Widths, levels and frame layout
   localparam int unsigned TMR_W      = 20;
   localparam int unsigned LVL_W      = 9;
   localparam int unsigned RAMP_STEPS = 256;
   localparam logic [8:0]  LVL_FULL   = 9'h100;
   localparam logic [5:0]  FRAME_BITS = 6'h20;
   localparam logic [7:0]  CRC_POLY   = 8'h2f;
   localparam logic [7:0]  CRC_SEED   = 8'hff;
   localparam logic [3:0]  GLOBAL_ID  = 4'h0;
   localparam logic [3:0]  CNT_FIRST  = 4'h1;
   localparam logic [3:0]  CMD_WRITE  = 4'h2;
   localparam logic [7:0]  ADDR_REG   = 8'h00;

   // ==========================================================
   // Register offsets, fields and reset values
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_LAST_CMD = 8'h08;
   localparam logic [7:0] REG_ERR_CNT  = 8'h0c;
   localparam int unsigned CTRL_INIT_END = 0;
   localparam int unsigned CTRL_SWITCH   = 1;
   localparam logic [1:0]  CTRL_RST      = 2'h0;

   // ==========================================================
   // Discovery states and command frame
   typedef enum logic [1:0] {
      DS_IDLE  = 2'b00,
      DS_DELAY = 2'b01,
      DS_RAMP  = 2'b10,
      DS_HOLD  = 2'b11
   } dsa_disc_st_t;

   typedef struct packed {
      logic [3:0] target_slave_id;
      logic [3:0] cmd_code;
      logic [7:0] upper_data_byte;
      logic [7:0] lower_data_byte;
      logic [7:0] crc;
   } dsa_cmd_t;

endpackage
`default_nettype wire

// ===== dsa_addr_rx.sv
// Notes on behaviour
// - Nonzero stored address skips other assignment methods
// - Global write to zero assigns the address
// - Downstream switch stays off after power-up
// - Switch closes only after master configures it
// - Listen only unaddressed, before init end, timed
// - After delay, unaddressed device ramps to 2x
// - Sensed current above unit stops, counts up
// - Low sense: finish ramp, then hold level
// - Quiet hold end takes counter as address
// - Master then configures slaves by address
// - Transactions are one master, one slave
// - Frame is 32 bits MSB first, five fields
// - Act only when target id matches address
// - Downstream current sense reveals further slaves
// - CRC-8 poly 0x2f, seed ff, all bits
// - Bad CRC drops the frame, no response
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dsa_addr_rx
   import dsa_pkg::*;
#(
   parameter int unsigned LISTEN_CYC = LISTEN_START_CYC,
   parameter int unsigned PERIOD_CYC = DISC_PER_CYC,
   parameter int unsigned DELAY_CYC  = RAMP_DLY_CYC,
   parameter int unsigned RAMPT_CYC  = RAMP_CYC,
   parameter int unsigned HOLDT_CYC  = HOLD_CYC
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic             wb_ack_o,
   output logic      [31:0] wb_dat_o,
   // Stored address and decoded command bits
   input  wire logic [3:0]  otp_addr_i,
   input  wire logic        cmd_start_i,
   input  wire logic        cmd_bit_vld_i,
   input  wire logic        cmd_bit_i,
   input  wire logic        disc_cmd_i,
   // Downstream current comparator (asynchronous)
   input  wire logic        sense_over_i,
   // Discovery current, switch and address
   output logic             ramp_en_o,
   output logic [LVL_W-1:0] ramp_level_o,
   output logic             switch_on_o,
   output logic [3:0]       bus_address_o,
   // Accepted commands
   output dsa_cmd_t         cmd_o,
   output logic             cmd_vld_o,
   output logic             crc_err_o
);

   // ==========================================================
   // Derived counts
   localparam int unsigned STEP_CYC = (RAMPT_CYC / RAMP_STEPS > 0) ? RAMPT_CYC / RAMP_STEPS : 1;
   localparam int unsigned GAP_CYC  = (PERIOD_CYC / 2 > 0) ? PERIOD_CYC / 2 : 1;

   // ==========================================================
   // State
   logic [3:0]       bus_address_register_q;
   logic             loaded_q;
   logic             init_end_flag_q;
   logic             switch_en_q;
   logic             switch_q;
   logic [2:0]       sense_sync_q;
   logic             sense_q;
   logic [TMR_W-1:0] lst_tmr_q;
   logic             listen_q;
   logic             gap_q;
   dsa_disc_st_t     st_q;
   logic [TMR_W-1:0] tmr_q;
   logic [LVL_W-1:0] level_q;
   logic             ramp_q;
   logic [3:0]       cnt_q;
   logic [5:0]       bit_cnt_q;
   logic [31:0]      shift_q;
   logic [7:0]       crc_q;
   dsa_cmd_t         cmd_q;
   logic             cmd_vld_q;
   logic             crc_err_q;
   logic [7:0]       err_cnt_q;
   logic             ack_q;
   logic [31:0]      dat_q;
   // One serial CRC step, message rotated in at the low end
   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
      logic [7:0] n;
      n = {c[6:0], b};
      if (c[7]) begin
         n = n ^ CRC_POLY;
      end
      return n;
   endfunction

   // ==========================================================
   // Combinational decode
   logic        listen_ok;
   logic        disc_go;
   logic        disc_take;
   logic        frame_done;
   logic [31:0] frm;
   dsa_cmd_t    frm_c;
   logic [7:0]  crc_fin;
   logic        crc_ok;
   logic        id_match;
   logic        glob_set;
   logic        wb_hit;
   // Only an unaddressed device still before init end listens
   assign listen_ok  = loaded_q & ~init_end_flag_q &
                       (bus_address_register_q == GLOBAL_ID);
   assign disc_go    = disc_cmd_i & listen_q & ~gap_q & listen_ok &
                       (st_q == DS_IDLE);
   assign disc_take  = (st_q == DS_HOLD) & ~sense_q &
                       (tmr_q == TMR_W'(HOLDT_CYC - 1));
   assign frame_done = cmd_bit_vld_i & (bit_cnt_q == FRAME_BITS - 6'h01);
   assign frm        = {shift_q[30:0], cmd_bit_i};
   assign frm_c      = dsa_cmd_t'(frm);
   assign crc_fin    = crc_step(crc_q, cmd_bit_i);
   assign crc_ok     = (crc_fin == 8'h00);
   assign id_match   = (frm_c.target_slave_id == bus_address_register_q);
   // Global write assigning the address, only while unaddressed
   assign glob_set   = frame_done & crc_ok & loaded_q &
                       (bus_address_register_q == GLOBAL_ID) &
                       (frm_c.target_slave_id == GLOBAL_ID) &
                       (frm_c.cmd_code == CMD_WRITE) &
                       (frm_c.upper_data_byte == ADDR_REG) &
                       (frm_c.lower_data_byte[3:0] != 4'h0);
   assign wb_hit     = wb_cyc_i & wb_stb_i & ~ack_q;
   // ==========================================================
   // Address register: stored value caught after reset release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_address_register_q <= 4'h0;
         loaded_q               <= 1'b0;
      end else if (!loaded_q) begin
         bus_address_register_q <= otp_addr_i;
         loaded_q               <= 1'b1;
      end else if (glob_set) begin
         bus_address_register_q <= frm_c.lower_data_byte[3:0];
      end else if (disc_take) begin
         bus_address_register_q <= cnt_q;
      end
   end
   // Sense comparator: three flops, change taken when 2nd and 3rd agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sense_sync_q <= 3'h0;
         sense_q      <= 1'b0;
      end else begin
         sense_sync_q <= {sense_sync_q[1:0], sense_over_i};
         if (sense_sync_q[1] == sense_sync_q[2]) begin
            sense_q <= sense_sync_q[2];
         end
      end
   end
   // Listen window: opens after start time, then one command per period
   // Reopening at half a period tolerates master timing jitter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lst_tmr_q <= '0;
         listen_q  <= 1'b0;
         gap_q     <= 1'b0;
      end else if (!listen_q) begin
         lst_tmr_q <= lst_tmr_q + 1'b1;
         if (lst_tmr_q == TMR_W'(LISTEN_CYC - 1)) begin
            listen_q  <= 1'b1;
            lst_tmr_q <= '0;
         end
      end else if (gap_q) begin
         lst_tmr_q <= lst_tmr_q + 1'b1;
         if (lst_tmr_q == TMR_W'(GAP_CYC - 1)) begin
            gap_q <= 1'b0;
         end
      end else if (disc_go) begin
         gap_q     <= 1'b1;
         lst_tmr_q <= '0;
      end
   end

   // ==========================================================
   // Discovery sequencer: delay, ramp to 2x, hold, decide
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q    <= DS_IDLE;
         tmr_q   <= '0;
         level_q <= '0;
         ramp_q  <= 1'b0;
         cnt_q   <= CNT_FIRST;
      end else if (st_q != DS_IDLE && !listen_ok) begin
         // Init end or an address from elsewhere aborts the ramp
         st_q    <= DS_IDLE;
         ramp_q  <= 1'b0;
         level_q <= '0;
      end else begin
         case (st_q)
            DS_IDLE: begin
               if (disc_go) begin
                  st_q  <= DS_DELAY;
                  tmr_q <= '0;
               end
            end
            DS_DELAY: begin
               tmr_q <= tmr_q + 1'b1;
               if (tmr_q == TMR_W'(DELAY_CYC - 1)) begin
                  st_q    <= DS_RAMP;
                  tmr_q   <= '0;
                  ramp_q  <= 1'b1;
                  level_q <= '0;
               end
            end
            DS_RAMP, DS_HOLD: begin
               if (sense_q) begin
                  // Someone downstream answers: back off and count
                  st_q    <= DS_IDLE;
                  ramp_q  <= 1'b0;
                  level_q <= '0;
                  if (cnt_q != 4'hf) begin
                     cnt_q <= cnt_q + 4'h1;
                  end
               end else if (st_q == DS_RAMP) begin
                  tmr_q <= tmr_q + 1'b1;
                  if (tmr_q == TMR_W'(STEP_CYC - 1)) begin
                     tmr_q   <= '0;
                     level_q <= level_q + 1'b1;
                     if (level_q == LVL_FULL - 9'h001) begin
                        st_q <= DS_HOLD;
                     end
                  end
               end else begin
                  tmr_q <= tmr_q + 1'b1;
                  if (disc_take) begin
                     st_q    <= DS_IDLE;
                     ramp_q  <= 1'b0;
                     level_q <= '0;
                  end
               end
            end
            default: begin
               st_q <= DS_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Command frame shifter and CRC, restarted by each frame start
   always_ff @(posedge clk_i) begin
      if (rst_i || cmd_start_i) begin
         bit_cnt_q <= 6'h00;
         shift_q   <= 32'h0;
         crc_q     <= CRC_SEED;
      end else if (cmd_bit_vld_i && bit_cnt_q != FRAME_BITS) begin
         bit_cnt_q <= bit_cnt_q + 6'h01;
         shift_q   <= frm;
         crc_q     <= crc_fin;
      end
   end
   // Accepted command out; bad CRC is dropped, flagged on crc_err_o and counted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_q     <= '0;
         cmd_vld_q <= 1'b0;
         crc_err_q <= 1'b0;
         err_cnt_q <= 8'h00;
      end else begin
         cmd_vld_q <= frame_done & crc_ok & id_match;
         crc_err_q <= frame_done & ~crc_ok;
         if (frame_done && crc_ok && id_match) begin
            cmd_q <= frm_c;
         end
         if (frame_done && !crc_ok && err_cnt_q != 8'hff) begin
            err_cnt_q <= err_cnt_q + 8'h01;
         end
      end
   end

   // ==========================================================
   // Wishbone: ack one cycle after strobe, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= wb_hit;
         if (wb_hit) begin
            case (wb_adr_i)
               REG_CTRL:     dat_q <= {30'h0, switch_en_q, init_end_flag_q};
               REG_STATUS:   dat_q <= {16'h0, listen_q, ramp_q, st_q,
                                       cnt_q, 4'h0, bus_address_register_q};
               REG_LAST_CMD: dat_q <= cmd_q;
               REG_ERR_CNT:  dat_q <= {24'h0, err_cnt_q};
               default:      dat_q <= 32'h0;
            endcase
         end
      end
   end
   // Control register: init end and switch request from the master
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {switch_en_q, init_end_flag_q} <= CTRL_RST;
      end else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL) begin
         init_end_flag_q <= wb_dat_i[CTRL_INIT_END];
         switch_en_q     <= wb_dat_i[CTRL_SWITCH];
      end
   end
   // Switch closes only once addressed and configured
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         switch_q <= 1'b0;
      end else begin
         switch_q <= switch_en_q & (bus_address_register_q != 4'h0);
      end
   end

   // ==========================================================
   // Outputs, each from a flip-flop
   assign wb_ack_o      = ack_q;
   assign wb_dat_o      = dat_q;
   assign ramp_en_o     = ramp_q;
   assign ramp_level_o  = level_q;
   assign switch_on_o   = switch_q;
   assign bus_address_o = bus_address_register_q;
   assign cmd_o         = cmd_q;
   assign cmd_vld_o     = cmd_vld_q;
   assign crc_err_o     = crc_err_q;

endmodule
`default_nettype wire

// ===== dsa_mst_mdl.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bus master model: command frames and discovery pulses
module dsa_mst_mdl (
   // Clock
   input  wire logic clk_i,
   // Decoded command line towards the slave
   output var  logic start_o,
   output var  logic bit_vld_o,
   output var  logic bit_o,
   output var  logic disc_o
);
   // Quiet line from time zero
   initial begin
      start_o   = 1'h0;
      bit_vld_o = 1'h0;
      bit_o     = 1'h0;
      disc_o    = 1'h0;
   end
   // Check byte that leaves a zero remainder over the whole frame
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0]  c;
      logic [31:0] m;
      c = 8'hff;
      m = {d, 8'h00};
      for (int i = 31; i >= 0; i--) begin
         c = c[7] ? ({c[6:0], m[i]} ^ 8'h2f) : {c[6:0], m[i]};
      end
      return c;
   endfunction
   // One frame to one slave: start pulse, then 32 bits back to back
   task automatic send_frame(input logic [31:0] f);
      start_o <= 1'h1;
      @(posedge clk_i);
      start_o <= 1'h0;
      for (int i = 31; i >= 0; i--) begin
         bit_vld_o <= 1'h1;
         bit_o     <= f[i];
         @(posedge clk_i);
      end
      bit_vld_o <= 1'h0;
      bit_o     <= ~f[0]; // Released line must not echo the last bit
   endtask
   // Discovery command; the caller spaces them one period apart
   task automatic send_disc();
      disc_o <= 1'h1;
      @(posedge clk_i);
      disc_o <= 1'h0;
   endtask
endmodule
`default_nettype wire

// ===== dsa_addr_rx_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port-level checks of the address and command block
module dsa_addr_rx_sva
   import dsa_pkg::*;
#(
   parameter int unsigned DELAY_CYC = RAMP_DLY_CYC
) (
   // Clock, reset and bus handshake
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_ack_o,
   // Command and discovery side
   input wire logic             cmd_bit_vld_i,
   input wire logic             disc_cmd_i,
   input wire logic             sense_over_i,
   input wire logic             ramp_en_o,
   input wire logic [LVL_W-1:0] ramp_level_o,
   input wire logic             switch_on_o,
   input wire logic [3:0]       bus_address_o,
   input wire dsa_cmd_t         cmd_o,
   input wire logic             cmd_vld_o,
   input wire logic             crc_err_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Steps shared by the properties
   sequence s_bus_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_frame_end; cmd_vld_o || crc_err_o; endsequence
   sequence s_sense_on; sense_over_i [*8]; endsequence
   property p_ack_resp; s_bus_req |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
   property p_end_bit; s_frame_end |-> $past(cmd_bit_vld_i); endproperty
   a_end_bit: assert property (p_end_bit) else $error("result not after last bit");
   property p_id_match; cmd_vld_o |-> cmd_o.target_slave_id == $past(bus_address_o); endproperty
   a_id_match: assert property (p_id_match) else $error("foreign frame accepted");
   property p_cmd_hold; !cmd_vld_o |-> $stable(cmd_o); endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("frame changed silently");
   property p_sw_addr; switch_on_o |-> $past(bus_address_o) != 4'h0; endproperty
   a_sw_addr: assert property (p_sw_addr) else $error("switch on unaddressed");
   // Slack of one cycle covers the comparator-free delay path
   property p_ramp_rise;
      $rose(ramp_en_o) |-> $past(disc_cmd_i, DELAY_CYC + 1) || $past(disc_cmd_i, DELAY_CYC + 2);
   endproperty
   a_ramp_rise: assert property (p_ramp_rise) else $error("ramp start mistimed");
   property p_addressed; bus_address_o != 4'h0 && $past(bus_address_o) != 4'h0 |-> !ramp_en_o;
   endproperty
   a_addressed: assert property (p_addressed) else $error("addressed slave ramps");
   property p_sense_stop; s_sense_on |-> !ramp_en_o; endproperty
   a_sense_stop: assert property (p_sense_stop) else $error("ramp ignores sense");
   property p_take_addr;
      $changed(bus_address_o) && $past(ramp_en_o) |-> $past(ramp_level_o) == LVL_FULL;
   endproperty
   a_take_addr: assert property (p_take_addr) else $error("address before full ramp");
endmodule
bind dsa_addr_rx dsa_addr_rx_sva #(.DELAY_CYC(DELAY_CYC)) chk_u (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cmd_bit_vld_i, .disc_cmd_i,
   .sense_over_i, .ramp_en_o, .ramp_level_o, .switch_on_o, .bus_address_o, .cmd_o,
   .cmd_vld_o, .crc_err_o);
`default_nettype wire

// ===== dsa_addr_rx_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench of the address and command block
module dsa_addr_rx_tb;
   import dsa_pkg::*;
   // Short counts keep the run brief; one ramp step per cycle
   localparam int unsigned LSN = 40;
   localparam int unsigned PER = 40;
   localparam int unsigned DLY = 4;
   logic             clk_i = 1'h0;
   logic             rst_i = 1'h1;
   logic             wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [7:0]       wb_adr_i = 8'h00;
   logic [3:0]       wb_sel_i = 4'hf, otp_addr_i = 4'h0, bus_address_o;
   logic [31:0]      wb_dat_i = 32'h0, wb_dat_o, rd;
   logic             sense_over_i = 1'h0, wb_ack_o, ramp_en_o, switch_on_o;
   logic             cmd_start_i, cmd_bit_vld_i, cmd_bit_i, disc_cmd_i, cmd_vld_o, crc_err_o;
   logic             got_vld, got_err, rose, full;
   logic [LVL_W-1:0] ramp_level_o;
   dsa_cmd_t         cmd_o;
   int               failures = 0, checks_done = 0, cyc_cnt = 0, n;
   dsa_addr_rx #(.LISTEN_CYC(LSN), .PERIOD_CYC(PER), .DELAY_CYC(DLY), .RAMPT_CYC(256),
      .HOLDT_CYC(8)) dut_u (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_ack_o, .wb_dat_o, .otp_addr_i, .cmd_start_i, .cmd_bit_vld_i, .cmd_bit_i,
      .disc_cmd_i, .sense_over_i, .ramp_en_o, .ramp_level_o, .switch_on_o, .bus_address_o,
      .cmd_o, .cmd_vld_o, .crc_err_o);
   dsa_mst_mdl mdl_u (.clk_i, .start_o(cmd_start_i), .bit_vld_o(cmd_bit_vld_i),
      .bit_o(cmd_bit_i), .disc_o(disc_cmd_i));
   // Clock and hang guard
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         failures++;
         give_verdict();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Classic cycle: hold until ack is sampled, then idle one cycle
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      if (wb_ack_o !== 1'h1) check("ack", 32'(wb_ack_o), 32'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic do_reset(input logic [3:0] otp);
      otp_addr_i <= otp;
      rst_i      <= 1'h1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (3) @(posedge clk_i);
   endtask
   // A result pulse lasts one cycle, so every edge of the window is looked at
   task automatic frame(input logic [31:0] f);
      mdl_u.send_frame(f);
      got_vld = 1'h0;
      got_err = 1'h0;
      repeat (3) begin
         @(posedge clk_i);
         got_vld |= (cmd_vld_o === 1'h1);
         got_err |= (crc_err_o === 1'h1);
      end
   endtask
   task automatic disc();
      mdl_u.send_disc();
      rose = 1'h0;
      repeat (2 * DLY + 6) begin
         @(posedge clk_i);
         rose |= (ramp_en_o === 1'h1);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   initial begin
      do_reset(4'h0);
      check("switch", 32'(switch_on_o), 32'h0);
      wb(1'h0, REG_STATUS, 32'h0);
      check("counter", 32'(rd[11:8]), 32'h1);
      wb(1'h0, 8'h10, 32'h0);
      check("unmapped", rd, 32'h0);
      wb(1'h1, REG_CTRL, 32'h2);
      check("switch early", 32'(switch_on_o), 32'h0);
      repeat (LSN + 4) @(posedge clk_i);
      disc();
      check("ramp", 32'(rose), 32'h1);
      full = 1'h0;
      n = 0;
      while (ramp_en_o !== 1'h0 && n < 400) begin
         full |= (ramp_level_o === LVL_FULL);
         @(posedge clk_i);
         n++;
      end
      check("full", 32'(full), 32'h1);
      check("addr", 32'(bus_address_o), 32'h1);
      repeat (2) @(posedge clk_i);
      check("switch", 32'(switch_on_o), 32'h1);
      frame(32'h181186b0);
      check("vld err", 32'({got_vld, got_err}), 32'h2);
      check("frame", cmd_o, 32'h181186b0);
      wb(1'h0, REG_LAST_CMD, 32'h0);
      check("last cmd", rd, 32'h181186b0);
      frame(32'h2125ff38);
      check("other id", 32'({got_vld, got_err}), 32'h0);
      frame(32'h181186b1);
      check("bad crc", 32'({got_vld, got_err}), 32'h1);
      wb(1'h0, REG_ERR_CNT, 32'h0);
      check("errors", rd, 32'h1);
      repeat (PER) @(posedge clk_i);
      disc();
      check("ramp again", 32'(rose), 32'h0);
      $display("test quiet discovery done");
      do_reset(4'h0);
      repeat (LSN + 4) @(posedge clk_i);
      disc();
      check("ramp", 32'(rose), 32'h1);
      sense_over_i <= 1'h1;
      repeat (10) @(posedge clk_i);
      check("ramp off", 32'({ramp_en_o, ramp_level_o}), 32'h0);
      sense_over_i <= 1'h0;
      wb(1'h0, REG_STATUS, 32'h0);
      check("status", 32'({rd[11:8], rd[3:0]}), 32'h20);
      wb_sel_i <= 4'he;
      wb(1'h1, REG_CTRL, 32'h1);
      wb_sel_i <= 4'hf;
      wb(1'h0, REG_CTRL, 32'h0);
      check("no lane", rd, 32'h0);
      wb(1'h1, REG_CTRL, 32'h1);
      wb(1'h0, REG_CTRL, 32'h0);
      check("ctrl", rd, 32'h1);
      repeat (PER) @(posedge clk_i);
      disc();
      check("init end", 32'(rose), 32'h0);
      frame({24'h020007, mdl_u.crc8(24'h020007)});
      check("global", 32'(bus_address_o), 32'h7);
      $display("test sensed discovery done");
      do_reset(4'h5);
      check("stored", 32'(bus_address_o), 32'h5);
      repeat (LSN + 4) @(posedge clk_i);
      disc();
      check("no ramp", 32'(rose), 32'h0);
      frame({24'h510000, mdl_u.crc8(24'h510000)});
      check("own id", 32'(got_vld), 32'h1);
      $display("test stored address done");
      give_verdict();
   end
endmodule
`default_nettype wire
